// *** pgas_pkg.sv ***
// Constants for the power-good aggregation and error status block
//
// Summary of operation
// - Moderate status bit0: ordered thermal shutdown
// - Severe status bit1: supply overvoltage protection
// - Severe status bit0: immediate thermal shutdown
// - Readback bit3: SoC reset pin mismatch
// - Readback bit2: general reset pin mismatch
// - Readback bit1: interrupt pin mismatch
// - Readback bit0: driver-enable pin any mismatch
// - Regulator fields: mask, voltage, voltage plus current
// - Config fields load from nonvolatile memory
// - Bit7 window: undervoltage only, or both
// - Bit6 inverts power-good output polarity
// - Bit5: SoC reset low forces invalid
// - Bit4: general reset low forces invalid
// - Bit3: thermal warning forces invalid
// - Bit2: second monitor participates
// - Bit1: first monitor participates
// - Bit0: supply monitor participates
package pgas_pkg;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [7:0] MODERATE_ERROR_STATUS_OFS = 8'h75;
    localparam logic [7:0] SEVERE_ERROR_STATUS_OFS = 8'h76;
    localparam logic [7:0] PIN_READBACK_ERROR_STATUS_OFS = 8'h77;
    localparam logic [7:0] REGULATOR_GOOD_SOURCE_SELECT_OFS = 8'h78;
    localparam logic [7:0] MISC_GOOD_SOURCE_SELECT_OFS = 8'h7b;
    localparam logic [7:0] EVENT_STATUS_OFS = 8'hf0;
    localparam logic [7:0] EVENT_MASK_OFS = 8'hf1;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [7:0] REGULATOR_GOOD_SOURCE_SELECT_RST = 8'h00;
    localparam logic [7:0] MISC_GOOD_SOURCE_SELECT_RST = 8'h00;
    localparam logic [7:0] EVENT_MASK_RST = 8'h00;

    // ************************************************************
    // Field positions of the misc select register
    // ************************************************************
    localparam int GOOD_WINDOW_TYPE_BIT = 7;
    localparam int GOOD_OUTPUT_POLARITY_BIT = 6;
    localparam int SOC_RESET_GOOD_SELECT_BIT = 5;
    localparam int GENERAL_RESET_GOOD_SELECT_BIT = 4;
    localparam int THERMAL_WARNING_GOOD_SELECT_BIT = 3;
    localparam int MONITOR2_GOOD_SELECT_BIT = 2;
    localparam int MONITOR1_GOOD_SELECT_BIT = 1;
    localparam int SUPPLY_GOOD_SELECT_BIT = 0;

    // Regulator select field width and codes
    localparam int REGULATOR_SELECT_WIDTH = 2;
    localparam logic [1:0] REGULATOR_SELECT_MASKED = 2'h0;
    localparam logic [1:0] REGULATOR_SELECT_VOLTAGE = 2'h1;

    // ************************************************************
    // Event status bit positions
    // ************************************************************
    localparam int EVENT_ORDERED_SHUTDOWN_BIT = 0;
    localparam int EVENT_IMMEDIATE_SHUTDOWN_BIT = 1;
    localparam int EVENT_SUPPLY_OVERVOLTAGE_BIT = 2;
    localparam int EVENT_READBACK_BIT = 3;
    localparam int EVENT_GOOD_LOST_BIT = 4;
    localparam int EVENT_COUNT = 5;

    // Pin readback latency: drive level is delayed to match the pin synchroniser
    localparam int READBACK_DELAY_CYCLES = 2;

endpackage

// *** pgas_top.sv ***
// Power-good aggregation with error status registers and event interrupt
`timescale 1ns/1ps
`default_nettype none

module pgas_top #(
    parameter int REGULATOR_COUNT = 4
) (
    input wire logic SYS_CLK,
    input wire logic RST_N,
    // Register port
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [7:0] REG_RDATA,
    // Nonvolatile configuration load, same clock domain
    input wire logic NVM_LOAD,
    input wire logic [7:0] NVM_REGULATOR_SELECT,
    input wire logic [7:0] NVM_MISC_SELECT,
    // Analog monitor results, asynchronous
    input wire logic [REGULATOR_COUNT-1:0] REGULATOR_UV,
    input wire logic [REGULATOR_COUNT-1:0] REGULATOR_OV,
    input wire logic [REGULATOR_COUNT-1:0] REGULATOR_ILIM,
    input wire logic MONITOR1_UV,
    input wire logic MONITOR1_OV,
    input wire logic MONITOR2_UV,
    input wire logic MONITOR2_OV,
    input wire logic SUPPLY_UV,
    input wire logic SUPPLY_OV,
    input wire logic THERMAL_WARNING,
    input wire logic ORDERED_SHUTDOWN_TEMP,
    input wire logic IMMEDIATE_SHUTDOWN_TEMP,
    input wire logic SUPPLY_OVP,
    // Pin drive commands from device logic, same clock domain
    input wire logic SOC_RESET_OUTPUT_DRIVE_LOW,
    input wire logic GENERAL_RESET_OUTPUT_DRIVE_LOW,
    input wire logic INTERRUPT_OUTPUT_DRIVE_LOW,
    input wire logic DRIVER_ENABLE_DRIVE,
    // Pin readback levels, asynchronous
    input wire logic SOC_RESET_OUTPUT_PIN,
    input wire logic GENERAL_RESET_OUTPUT_PIN,
    input wire logic INTERRUPT_OUTPUT_PIN,
    input wire logic DRIVER_ENABLE_PIN,
    // Results
    output logic POWER_GOOD_OUTPUT,
    output logic IRQ
);
    import pgas_pkg::*;

    // ************************************************************
    // Input synchronisers
    // ************************************************************
    localparam int ASYNC_WIDTH = 3 * REGULATOR_COUNT + 14;

    logic [ASYNC_WIDTH-1:0] async_in;
    logic [ASYNC_WIDTH-1:0] sync1_reg;
    logic [ASYNC_WIDTH-1:0] sync2_reg;

    assign async_in = {REGULATOR_UV, REGULATOR_OV, REGULATOR_ILIM,
                       MONITOR1_UV, MONITOR1_OV, MONITOR2_UV, MONITOR2_OV,
                       SUPPLY_UV, SUPPLY_OV, THERMAL_WARNING,
                       ORDERED_SHUTDOWN_TEMP, IMMEDIATE_SHUTDOWN_TEMP, SUPPLY_OVP,
                       SOC_RESET_OUTPUT_PIN, GENERAL_RESET_OUTPUT_PIN,
                       INTERRUPT_OUTPUT_PIN, DRIVER_ENABLE_PIN};

    // Two flops; only the second stage is read by logic
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else begin
            sync1_reg <= async_in;
            sync2_reg <= sync1_reg;
        end
    end

    logic [REGULATOR_COUNT-1:0] reg_uv;
    logic [REGULATOR_COUNT-1:0] reg_ov;
    logic [REGULATOR_COUNT-1:0] reg_ilim;
    logic mon1_uv;
    logic mon1_ov;
    logic mon2_uv;
    logic mon2_ov;
    logic sup_uv;
    logic sup_ov;
    logic thermal_warn;
    logic ordered_tsd;
    logic immediate_tsd;
    logic supply_ovp;
    logic soc_reset_pin;
    logic general_reset_pin;
    logic interrupt_pin;
    logic driver_enable_pin;

    assign {reg_uv, reg_ov, reg_ilim,
            mon1_uv, mon1_ov, mon2_uv, mon2_ov,
            sup_uv, sup_ov, thermal_warn,
            ordered_tsd, immediate_tsd, supply_ovp,
            soc_reset_pin, general_reset_pin,
            interrupt_pin, driver_enable_pin} = sync2_reg;

    // ************************************************************
    // Configuration registers
    // ************************************************************
    logic [7:0] regulator_good_source_select_reg;
    logic [7:0] misc_good_source_select_reg;
    logic [7:0] event_mask_reg;

    // Software writes and nonvolatile load; a load in the same cycle wins
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            regulator_good_source_select_reg <= REGULATOR_GOOD_SOURCE_SELECT_RST;
            misc_good_source_select_reg <= MISC_GOOD_SOURCE_SELECT_RST;
        end else if (NVM_LOAD) begin
            regulator_good_source_select_reg <= NVM_REGULATOR_SELECT;
            misc_good_source_select_reg <= NVM_MISC_SELECT;
        end else if (REG_WR) begin
            if (REG_ADDR == REGULATOR_GOOD_SOURCE_SELECT_OFS) begin
                regulator_good_source_select_reg <= REG_WDATA;
            end
            if (REG_ADDR == MISC_GOOD_SOURCE_SELECT_OFS) begin
                misc_good_source_select_reg <= REG_WDATA;
            end
        end
    end

    // Event mask, software only
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            event_mask_reg <= EVENT_MASK_RST;
        end else if (REG_WR && REG_ADDR == EVENT_MASK_OFS) begin
            event_mask_reg <= REG_WDATA;
        end
    end

    // ************************************************************
    // Source evaluation
    // ************************************************************
    logic window_both;
    logic polarity_low;

    assign window_both = misc_good_source_select_reg[GOOD_WINDOW_TYPE_BIT];
    assign polarity_low = misc_good_source_select_reg[GOOD_OUTPUT_POLARITY_BIT];

    // Voltage fault: overvoltage only counts in window mode
    function automatic logic volt_fault(input logic uv, input logic ov, input logic both);
        volt_fault = uv | (both & ov);
    endfunction

    logic [REGULATOR_COUNT-1:0] regulator_fault;

    genvar gi;
    generate
        for (gi = 0; gi < REGULATOR_COUNT; gi++) begin : g_reg
            logic [1:0] sel;
            assign sel = regulator_good_source_select_reg[
                gi*REGULATOR_SELECT_WIDTH +: REGULATOR_SELECT_WIDTH];
            // Codes above voltage-only also watch the current limit
            assign regulator_fault[gi] = (sel != REGULATOR_SELECT_MASKED) &
                (volt_fault(reg_uv[gi], reg_ov[gi], window_both) |
                 ((sel != REGULATOR_SELECT_VOLTAGE) & reg_ilim[gi]));
        end
    endgenerate

    logic soc_reset_fault;
    logic general_reset_fault;
    logic thermal_fault;
    logic mon2_fault;
    logic mon1_fault;
    logic supply_fault;
    logic good_valid;

    // Each misc source only counts when its select bit is set
    assign soc_reset_fault = misc_good_source_select_reg[SOC_RESET_GOOD_SELECT_BIT]
                             & ~soc_reset_pin;
    assign general_reset_fault = misc_good_source_select_reg[GENERAL_RESET_GOOD_SELECT_BIT]
                                 & ~general_reset_pin;
    assign thermal_fault = misc_good_source_select_reg[THERMAL_WARNING_GOOD_SELECT_BIT]
                           & thermal_warn;
    assign mon2_fault = misc_good_source_select_reg[MONITOR2_GOOD_SELECT_BIT]
                        & volt_fault(mon2_uv, mon2_ov, window_both);
    assign mon1_fault = misc_good_source_select_reg[MONITOR1_GOOD_SELECT_BIT]
                        & volt_fault(mon1_uv, mon1_ov, window_both);
    assign supply_fault = misc_good_source_select_reg[SUPPLY_GOOD_SELECT_BIT]
                          & volt_fault(sup_uv, sup_ov, window_both);

    // All sources masked means valid
    assign good_valid = ~(|regulator_fault | soc_reset_fault | general_reset_fault |
                          thermal_fault | mon2_fault | mon1_fault | supply_fault);

    logic good_valid_reg;
    logic power_good_reg;

    // Registered output with polarity applied; low during reset
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            good_valid_reg <= 1'b0;
            power_good_reg <= 1'b0;
        end else begin
            good_valid_reg <= good_valid;
            power_good_reg <= good_valid ^ polarity_low;
        end
    end

    assign POWER_GOOD_OUTPUT = power_good_reg;

    // ************************************************************
    // Pin readback checks
    // ************************************************************
    // Drive levels delayed to line up with the synchronised pin levels,
    // so a legitimate edge is never flagged as a mismatch
    logic [3:0] drive_dly_reg [READBACK_DELAY_CYCLES];
    logic [3:0] drive_now;

    assign drive_now = {SOC_RESET_OUTPUT_DRIVE_LOW, GENERAL_RESET_OUTPUT_DRIVE_LOW,
                        INTERRUPT_OUTPUT_DRIVE_LOW, DRIVER_ENABLE_DRIVE};

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            for (int i = 0; i < READBACK_DELAY_CYCLES; i++) begin
                drive_dly_reg[i] <= 4'h0;
            end
        end else begin
            drive_dly_reg[0] <= drive_now;
            for (int i = 1; i < READBACK_DELAY_CYCLES; i++) begin
                drive_dly_reg[i] <= drive_dly_reg[i-1];
            end
        end
    end

    logic [3:0] drive_seen;
    logic [7:0] pin_readback_error_status;

    assign drive_seen = drive_dly_reg[READBACK_DELAY_CYCLES-1];

    // Open-drain pins only flag a high pin while driven low
    assign pin_readback_error_status = {4'h0,
        drive_seen[3] & soc_reset_pin,
        drive_seen[2] & general_reset_pin,
        drive_seen[1] & interrupt_pin,
        drive_seen[0] ^ driver_enable_pin};

    // ************************************************************
    // Error status views
    // ************************************************************
    logic [7:0] moderate_error_status;
    logic [7:0] severe_error_status;

    assign moderate_error_status = {7'h00, ordered_tsd};
    assign severe_error_status = {6'h00, supply_ovp, immediate_tsd};

    // ************************************************************
    // Event status and interrupt
    // ************************************************************
    logic [EVENT_COUNT-1:0] level_now;
    logic [EVENT_COUNT-1:0] level_prev_reg;
    logic [EVENT_COUNT-1:0] event_rise;
    logic [EVENT_COUNT-1:0] event_status_reg;
    logic event_read;

    assign level_now[EVENT_ORDERED_SHUTDOWN_BIT] = ordered_tsd;
    assign level_now[EVENT_IMMEDIATE_SHUTDOWN_BIT] = immediate_tsd;
    assign level_now[EVENT_SUPPLY_OVERVOLTAGE_BIT] = supply_ovp;
    assign level_now[EVENT_READBACK_BIT] = |pin_readback_error_status;
    assign level_now[EVENT_GOOD_LOST_BIT] = ~good_valid_reg;
    assign event_rise = level_now & ~level_prev_reg;
    assign event_read = REG_RD && REG_ADDR == EVENT_STATUS_OFS;

    // Rising edges of each condition; prev starts at zero so a fault
    // present out of reset is reported once
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            level_prev_reg <= '0;
        end else begin
            level_prev_reg <= level_now;
        end
    end

    // Sticky bits cleared by read; a new event in the read cycle survives
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            event_status_reg <= '0;
        end else if (event_read) begin
            event_status_reg <= event_rise;
        end else begin
            event_status_reg <= event_status_reg | event_rise;
        end
    end

    assign IRQ = |(event_status_reg & event_mask_reg[EVENT_COUNT-1:0]);

    // ************************************************************
    // Register read port
    // ************************************************************
    logic [7:0] rdata_next;
    logic [7:0] rdata_reg;

    // Unmapped addresses read zero
    always_comb begin
        case (REG_ADDR)
            MODERATE_ERROR_STATUS_OFS: rdata_next = moderate_error_status;
            SEVERE_ERROR_STATUS_OFS: rdata_next = severe_error_status;
            PIN_READBACK_ERROR_STATUS_OFS: rdata_next = pin_readback_error_status;
            REGULATOR_GOOD_SOURCE_SELECT_OFS: rdata_next = regulator_good_source_select_reg;
            MISC_GOOD_SOURCE_SELECT_OFS: rdata_next = misc_good_source_select_reg;
            EVENT_STATUS_OFS: rdata_next = {{(8-EVENT_COUNT){1'b0}}, event_status_reg};
            EVENT_MASK_OFS: rdata_next = event_mask_reg;
            default: rdata_next = 8'h00;
        endcase
    end

    // Data valid only in the cycle after the read strobe
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            rdata_reg <= 8'h00;
        end else if (REG_RD) begin
            rdata_reg <= rdata_next;
        end else begin
            rdata_reg <= 8'h00;
        end
    end

    assign REG_RDATA = rdata_reg;

endmodule

`default_nettype wire

// *** pgas_top_properties.sv ***
// Port-level assertions for the power-good aggregation block
`timescale 1ns/1ps
`default_nettype none
module pgas_top_properties (
    input wire logic SYS_CLK,
    input wire logic RST_N,
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [7:0] REG_RDATA,
    input wire logic NVM_LOAD,
    input wire logic [7:0] NVM_REGULATOR_SELECT,
    input wire logic [7:0] NVM_MISC_SELECT,
    input wire logic SUPPLY_UV,
    input wire logic THERMAL_WARNING,
    input wire logic ORDERED_SHUTDOWN_TEMP,
    input wire logic IMMEDIATE_SHUTDOWN_TEMP,
    input wire logic SUPPLY_OVP,
    input wire logic SOC_RESET_OUTPUT_PIN,
    input wire logic GENERAL_RESET_OUTPUT_PIN,
    input wire logic POWER_GOOD_OUTPUT
);
    import pgas_pkg::*;
    // ********
    // Helper state
    // ********
    logic [6:0] vec_now;
    logic [6:0] vec_reg;
    logic [2:0] quiet_reg;
    logic [2:0] age_reg;
    logic [7:0] sel_reg;
    logic [7:0] misc_reg;
    logic steady;
    logic cfg_ok;
    assign vec_now = {ORDERED_SHUTDOWN_TEMP, IMMEDIATE_SHUTDOWN_TEMP, SUPPLY_OVP, SUPPLY_UV,
        THERMAL_WARNING, SOC_RESET_OUTPUT_PIN, GENERAL_RESET_OUTPUT_PIN};
    // Held long enough to have crossed the synchroniser and output flop
    assign steady = (quiet_reg >= 3'h5) && (vec_now == vec_reg);
    assign cfg_ok = age_reg >= 3'h3;
    // Cycles since a watched input last moved
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            vec_reg <= 7'h00;
            quiet_reg <= 3'h0;
        end else begin
            vec_reg <= vec_now;
            quiet_reg <= (vec_now != vec_reg) ? 3'h0 : quiet_reg + {2'h0, quiet_reg != 3'h7};
        end
    end
    // Select shadow; a load beats a same-cycle write
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            sel_reg <= 8'h00;
            misc_reg <= 8'h00;
            age_reg <= 3'h0;
        end else begin
            if (NVM_LOAD) begin
                sel_reg <= NVM_REGULATOR_SELECT;
                misc_reg <= NVM_MISC_SELECT;
            end else if (REG_WR && REG_ADDR == REGULATOR_GOOD_SOURCE_SELECT_OFS) begin
                sel_reg <= REG_WDATA;
            end else if (REG_WR && REG_ADDR == MISC_GOOD_SOURCE_SELECT_OFS) begin
                misc_reg <= REG_WDATA;
            end
            age_reg <= (NVM_LOAD || REG_WR) ? 3'h0 : age_reg + {2'h0, age_reg != 3'h7};
        end
    end
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);
    rdata_idle_a: assert property (!$past(REG_RD) |-> REG_RDATA == 8'h00)
        else $error("read data not zero outside a read");
    moderate_read_a: assert property ($past(REG_RD) && $past(REG_ADDR) == 8'h75 && steady
        |-> REG_RDATA == {7'h00, ORDERED_SHUTDOWN_TEMP}) else $error("moderate status wrong");
    severe_read_a: assert property ($past(REG_RD) && $past(REG_ADDR) == 8'h76
        && steady |-> REG_RDATA == {6'h00, SUPPLY_OVP, IMMEDIATE_SHUTDOWN_TEMP})
        else $error("severe status wrong");
    misc_read_a: assert property ($past(REG_RD) && $past(REG_ADDR) == 8'h7b
        && age_reg >= 3'h2 |-> REG_RDATA == misc_reg) else $error("misc select readback wrong");
    idle_polarity_a: assert property (cfg_ok && sel_reg == 8'h00
        && misc_reg[5:0] == 6'h00 |-> POWER_GOOD_OUTPUT == !misc_reg[6])
        else $error("idle power good level wrong");
    soc_force_a: assert property (cfg_ok && steady && misc_reg[5] && !SOC_RESET_OUTPUT_PIN
        |-> POWER_GOOD_OUTPUT == misc_reg[6]) else $error("soc reset low not forcing");
    gen_force_a: assert property (cfg_ok && steady && misc_reg[4]
        && !GENERAL_RESET_OUTPUT_PIN
        |-> POWER_GOOD_OUTPUT == misc_reg[6]) else $error("general reset low not forcing");
    thermal_force_a: assert property (cfg_ok && steady && misc_reg[3] && THERMAL_WARNING
        |-> POWER_GOOD_OUTPUT == misc_reg[6]) else $error("thermal warning not forcing");
    supply_force_a: assert property (cfg_ok && steady && misc_reg[0] && SUPPLY_UV
        |-> POWER_GOOD_OUTPUT == misc_reg[6]) else $error("supply undervoltage not forcing");
endmodule
bind pgas_top pgas_top_properties u_props (.*);
`default_nettype wire

// *** pgas_board.sv ***
// Board model of the pins around the power-good block
`timescale 1ns/1ps
`default_nettype none
module pgas_board (
    input wire logic soc_drive_low,
    input wire logic gen_drive_low,
    input wire logic int_drive_low,
    input wire logic drv_enable,
    input wire logic [3:0] stuck,
    output logic soc_pin,
    output logic gen_pin,
    output logic int_pin,
    output logic drv_pin
);
    // ********
    // Pins
    // ********
    // Open-drain pins pulled up; a shorted pin stays high despite the pull-down
    assign soc_pin = !soc_drive_low || stuck[0];
    assign gen_pin = !gen_drive_low || stuck[1];
    assign int_pin = !int_drive_low || stuck[2];
    // Push-pull enable; a fault shows the inverse of the drive
    assign drv_pin = drv_enable ^ stuck[3];
endmodule
`default_nettype wire

// *** power_good_aggregation_status_bench.sv ***
// Self-checking bench for the power-good aggregation block
`timescale 1ns/1ps
`default_nettype none
module power_good_aggregation_status_bench;
    import pgas_pkg::*;
    // ********
    // Stimulus and model state
    // ********
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic nvm_load = 1'b0;
    logic [7:0] nvm_reg = 8'h00;
    logic [7:0] nvm_misc = 8'h00;
    logic [3:0] uv = 4'h0;
    logic [3:0] ov = 4'h0;
    logic [3:0] ilim = 4'h0;
    logic [7:0] mon = 8'h00; // m1uv m1ov m2uv m2ov suv sov twarn
    logic [2:0] sd = 3'h0; // ordered, immediate, overvoltage protect
    logic [3:0] dl = 4'h0; // soc, gen, int drive low; enable drive
    logic [3:0] stuck = 4'h0;
    logic [7:0] rdata;
    logic soc_pin, gen_pin, int_pin, drv_pin, pg, irq;
    logic [31:0] seed = 32'hc1f0;
    logic [7:0] m_reg = 8'h00;
    logic [7:0] m_misc = 8'h00;
    logic [7:0] ofs [7] = '{8'h75, 8'h76, 8'h77, 8'h78, 8'h7b, 8'hf1, 8'h79};
    int n_fail = 0;
    int num_checks = 0;
    always #5 clk = ~clk;
    pgas_top u_dut (.SYS_CLK(clk), .RST_N(rst_n), .REG_ADDR(addr), .REG_WDATA(wdata),
        .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(rdata), .NVM_LOAD(nvm_load),
        .NVM_REGULATOR_SELECT(nvm_reg), .NVM_MISC_SELECT(nvm_misc), .REGULATOR_UV(uv),
        .REGULATOR_OV(ov), .REGULATOR_ILIM(ilim), .MONITOR1_UV(mon[0]), .MONITOR1_OV(mon[1]),
        .MONITOR2_UV(mon[2]), .MONITOR2_OV(mon[3]), .SUPPLY_UV(mon[4]), .SUPPLY_OV(mon[5]),
        .THERMAL_WARNING(mon[6]), .ORDERED_SHUTDOWN_TEMP(sd[0]),
        .IMMEDIATE_SHUTDOWN_TEMP(sd[1]), .SUPPLY_OVP(sd[2]), .SOC_RESET_OUTPUT_DRIVE_LOW(dl[0]),
        .GENERAL_RESET_OUTPUT_DRIVE_LOW(dl[1]), .INTERRUPT_OUTPUT_DRIVE_LOW(dl[2]),
        .DRIVER_ENABLE_DRIVE(dl[3]), .SOC_RESET_OUTPUT_PIN(soc_pin),
        .GENERAL_RESET_OUTPUT_PIN(gen_pin), .INTERRUPT_OUTPUT_PIN(int_pin),
        .DRIVER_ENABLE_PIN(drv_pin), .POWER_GOOD_OUTPUT(pg), .IRQ(irq));
    pgas_board u_board (.soc_drive_low(dl[0]), .gen_drive_low(dl[1]), .int_drive_low(dl[2]),
        .drv_enable(dl[3]), .stuck(stuck), .soc_pin(soc_pin), .gen_pin(gen_pin),
        .int_pin(int_pin), .drv_pin(drv_pin));
    // Shift the generator a whole word per draw so fields are not copies
    function automatic logic [31:0] rnd();
        repeat (32) seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction
    // Expected power-good level from the selects and live inputs
    function automatic logic model_pg();
        logic ok;
        ok = 1'b1;
        for (int i = 0; i < 4; i++) begin
            if (|m_reg[2*i +: 2] && (uv[i] || (m_misc[7] && ov[i]))) ok = 1'b0;
            if (m_reg[2*i+1] && ilim[i]) ok = 1'b0;
        end
        if (m_misc[5] && !soc_pin) ok = 1'b0;
        if (m_misc[4] && !gen_pin) ok = 1'b0;
        if (m_misc[3] && mon[6]) ok = 1'b0;
        if (m_misc[2] && (mon[2] || (m_misc[7] && mon[3]))) ok = 1'b0;
        if (m_misc[1] && (mon[0] || (m_misc[7] && mon[1]))) ok = 1'b0;
        if (m_misc[0] && (mon[4] || (m_misc[7] && mon[5]))) ok = 1'b0;
        return ok ^ m_misc[6];
    endfunction
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic bus_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    // Read data stands only in the cycle after the strobe
    task automatic bus_check(input string name, input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        check(name, rdata, exp);
    endtask
    task automatic finish_test();
        $display("Comparisons %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // Watchdog against a hung handshake
    initial begin
        #50000;
        n_fail++;
        finish_test();
    end
    initial begin
        logic [31:0] r;
        logic [31:0] q;
        logic [31:0] s;
        logic [31:0] t;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        bus_check("event", EVENT_STATUS_OFS, 8'h10);
        // Read-only places ignore writes; unmapped reads give zero
        bus_write(SEVERE_ERROR_STATUS_OFS, 8'hff);
        bus_write(PIN_READBACK_ERROR_STATUS_OFS, 8'hff);
        foreach (ofs[i]) bus_check("reset", ofs[i], 8'h00);
        // Unmasked event raises the interrupt; reading clears it
        bus_write(EVENT_MASK_OFS, 8'h04);
        @(posedge clk);
        sd <= 3'h4;
        repeat (5) @(posedge clk);
        bus_check("severe", SEVERE_ERROR_STATUS_OFS, 8'h02);
        check("irq", {7'h00, irq}, 8'h01);
        bus_check("event", EVENT_STATUS_OFS, 8'h04);
        check("irq", {7'h00, irq}, 8'h00);
        // Masked event still latches and appears once unmasked
        bus_write(EVENT_MASK_OFS, 8'h00);
        @(posedge clk);
        sd <= 3'h2;
        repeat (5) @(posedge clk);
        check("irq", {7'h00, irq}, 8'h00);
        bus_write(EVENT_MASK_OFS, 8'h02);
        #1;
        check("irq", {7'h00, irq}, 8'h01);
        bus_check("event", EVENT_STATUS_OFS, 8'h02);
        bus_check("severe", SEVERE_ERROR_STATUS_OFS, 8'h01);
        bus_write(EVENT_MASK_OFS, 8'h00);
        // Random sources, selects, pin faults and loads against the model
        for (int k = 0; k < 30; k++) begin
            r = rnd();
            q = rnd();
            s = rnd();
            t = rnd();
            @(posedge clk);
            uv <= r[3:0] & q[3:0] & s[3:0];
            ov <= r[7:4] & q[7:4];
            ilim <= r[11:8] & q[11:8] & s[11:8];
            mon <= r[19:12] & q[19:12] & s[19:12];
            sd <= r[22:20] & q[22:20];
            dl <= r[26:23];
            stuck <= r[30:27] & q[30:27];
            nvm_reg <= t[7:0];
            nvm_misc <= t[15:8];
            if (t[16]) begin
                @(posedge clk);
                nvm_load <= 1'b1;
                @(posedge clk);
                nvm_load <= 1'b0;
                m_reg = t[7:0];
                m_misc = t[15:8];
            end else begin
                bus_write(REGULATOR_GOOD_SOURCE_SELECT_OFS, t[23:16]);
                bus_write(MISC_GOOD_SOURCE_SELECT_OFS, t[31:24]);
                m_reg = t[23:16];
                m_misc = t[31:24];
            end
            repeat (6) @(posedge clk);
            #1;
            check("good", {7'h00, pg},
                {7'h00, model_pg()});
            bus_check("regsel", REGULATOR_GOOD_SOURCE_SELECT_OFS, m_reg);
            bus_check("miscsel", MISC_GOOD_SOURCE_SELECT_OFS, m_misc);
            bus_check("moderate", MODERATE_ERROR_STATUS_OFS, {7'h00, sd[0]});
            bus_check("severe", SEVERE_ERROR_STATUS_OFS, {6'h00, sd[2], sd[1]});
            bus_check("readback", PIN_READBACK_ERROR_STATUS_OFS, {4'h0, dl[0] & soc_pin,
                dl[1] & gen_pin, dl[2] & int_pin, dl[3] ^ drv_pin});
            check("irq", {7'h00, irq}, 8'h00);
        end
        finish_test();
    end
endmodule
`default_nettype wire
